// File: design/flrb_regs.vh
`ifndef FLRB_REGS_VH
`define FLRB_REGS_VH
// Register offsets (byte addresses on the serial link)
`define FLRB_ADDR_FAULT 8'h03
`define FLRB_ADDR_SENSE 8'h04
`define FLRB_ADDR_SOURCE 8'h05
`define FLRB_ADDR_AUX 8'h06
// Fault log bit positions
`define FLRB_BIT_OV 0
`define FLRB_BIT_UV 1
`define FLRB_BIT_OC 2
`define FLRB_BIT_PBAD 3
`define FLRB_BIT_ENCHG 4
`define FLRB_BIT_SHORT 5
`define FLRB_FAULT_MASK 8'h3F
// Reset values
`define FLRB_FAULT_RST 8'h00
`define FLRB_RESULT_RST 8'h00
`define FLRB_ALERT_EN_RST 6'h00
// Sense code above which current flows with the switch off: 1000 uV / 151 uV, rounded down
`define FLRB_SHORT_UV 1000
`define FLRB_SENSE_LSB_UV 151
`define FLRB_SHORT_CODE 8'h06
// Edges until the pin synchronisers show real pin levels after reset
`define FLRB_SETTLE_CYCLES 2'h2
`endif

// File: design/flrb_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous level
module flrb_sync (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg stage1;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // flrb_sync

// File: design/flrb_bank.v
`timescale 1ns/1ps
`include "flrb_regs.vh"
module flrb_bank (
  input wire CORE_CLK,
  input wire RST_N,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  input wire [5:0] ALERT_EN,
  input wire SWITCH_ON_CMD,
  input wire OC_FAULT,
  input wire BOARD_ACTIVATE,
  input wire OUTPUT_LEVEL_MONITOR,
  input wire HIGH_SUPPLY_TRIP_INPUT,
  input wire LOW_SUPPLY_TRIP_INPUT,
  input wire CONV_VALID,
  input wire [1:0] CONV_CHAN,
  input wire [7:0] CONV_CODE,
  output reg ALERT_N,
  output reg [7:0] FAULT_LOG
);
  localparam [1:0] CH_SENSE = 2'h0;
  localparam [1:0] CH_SOURCE = 2'h1;
  localparam [1:0] CH_AUX = 2'h2;

  reg [7:0] fault_history;
  reg [7:0] sense_voltage_result;
  reg [7:0] source_voltage_result;
  reg [7:0] aux_input_result;
  reg enable_prev;
  reg enable_seen;
  reg [5:0] event_now;
  reg [7:0] next_fault;
  reg [7:0] read_mux;
  wire enable_s;
  wire level_s;
  wire high_s;
  wire low_s;
  // Pin qualification, strobes and alert
  reg [1:0] settle;
  wire pins_valid;
  wire level_bad;
  wire high_trip;
  wire low_trip;
  wire enable_edge;
  wire short_seen;
  wire wr_fault;
  wire wr_sense;
  wire wr_source;
  wire wr_aux;
  wire load_sense;
  wire load_source;
  wire load_aux;
  wire alert_any;

  // Pin synchronisers
  flrb_sync u_sync_en (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din(BOARD_ACTIVATE),
    .dout(enable_s)
  );
  flrb_sync u_sync_fb (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din(OUTPUT_LEVEL_MONITOR),
    .dout(level_s)
  );
  flrb_sync u_sync_ov (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din(HIGH_SUPPLY_TRIP_INPUT),
    .dout(high_s)
  );
  flrb_sync u_sync_uv (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din(LOW_SUPPLY_TRIP_INPUT),
    .dout(low_s)
  );

  // Settle count: synchroniser outputs show reset values for two edges after release
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle <= 2'h0;
    end else if (settle != `FLRB_SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  // Pin faults count only once the synchronised levels are real, no false flags after reset
  assign pins_valid = (settle == `FLRB_SETTLE_CYCLES);
  assign level_bad = pins_valid && !level_s;
  assign high_trip = pins_valid && high_s;
  assign low_trip = pins_valid && !low_s;
  assign enable_edge = enable_seen && (enable_s != enable_prev);

  // Register strobes decoded once, shared by the write and load paths
  assign wr_fault = REG_WR && (REG_ADDR == `FLRB_ADDR_FAULT);
  assign wr_sense = REG_WR && (REG_ADDR == `FLRB_ADDR_SENSE);
  assign wr_source = REG_WR && (REG_ADDR == `FLRB_ADDR_SOURCE);
  assign wr_aux = REG_WR && (REG_ADDR == `FLRB_ADDR_AUX);
  assign load_sense = CONV_VALID && (CONV_CHAN == CH_SENSE);
  assign load_source = CONV_VALID && (CONV_CHAN == CH_SOURCE);
  assign load_aux = CONV_VALID && (CONV_CHAN == CH_AUX);

  // Switch-short test: current above the threshold while the switch is off
  assign short_seen = !SWITCH_ON_CMD && (sense_voltage_result > `FLRB_SHORT_CODE);

  // Fault events this cycle
  always @* begin
    event_now = 6'h00;
    event_now[`FLRB_BIT_SHORT] = short_seen;
    event_now[`FLRB_BIT_ENCHG] = enable_edge;
    event_now[`FLRB_BIT_PBAD] = level_bad;
    event_now[`FLRB_BIT_OC] = OC_FAULT;
    event_now[`FLRB_BIT_OV] = high_trip;
    event_now[`FLRB_BIT_UV] = low_trip;
  end

  // Host clear by writing zero, a new event wins over the clear
  always @* begin
    next_fault = fault_history;
    if (wr_fault) begin
      next_fault = fault_history & REG_WDATA;
    end
    next_fault = (next_fault | {2'b00, event_now}) & `FLRB_FAULT_MASK;
  end

  // Alert follows the enabled flags of the coming log value
  assign alert_any = |(next_fault[5:0] & ALERT_EN);

  // Read multiplexer, unmapped offsets read zero
  always @* begin
    case (REG_ADDR)
      `FLRB_ADDR_FAULT: read_mux = fault_history;
      `FLRB_ADDR_SENSE: read_mux = sense_voltage_result;
      `FLRB_ADDR_SOURCE: read_mux = source_voltage_result;
      `FLRB_ADDR_AUX: read_mux = aux_input_result;
      default: read_mux = 8'h00;
    endcase
  end

  // Enable pin edge tracking, edges count only once the synchronised pin is real
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_prev <= 1'b0;
      enable_seen <= 1'b0;
    end else begin
      enable_prev <= enable_s;
      enable_seen <= pins_valid;
    end
  end

  // Fault log and alert
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fault_history <= `FLRB_FAULT_RST;
      FAULT_LOG <= `FLRB_FAULT_RST;
      ALERT_N <= 1'b1;
    end else begin
      fault_history <= next_fault;
      FAULT_LOG <= next_fault;
      ALERT_N <= !alert_any;
    end
  end

  // Read port: data holds until the next read
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= read_mux;
      end
    end
  end

  // Sense result: converter load wins over a host write in the same cycle
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sense_voltage_result <= `FLRB_RESULT_RST;
    end else if (load_sense) begin
      sense_voltage_result <= CONV_CODE;
    end else if (wr_sense) begin
      sense_voltage_result <= REG_WDATA;
    end
  end

  // Source result: converter load wins over a host write in the same cycle
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      source_voltage_result <= `FLRB_RESULT_RST;
    end else if (load_source) begin
      source_voltage_result <= CONV_CODE;
    end else if (wr_source) begin
      source_voltage_result <= REG_WDATA;
    end
  end

  // Aux input result: converter load wins over a host write in the same cycle
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_input_result <= `FLRB_RESULT_RST;
    end else if (load_aux) begin
      aux_input_result <= CONV_CODE;
    end else if (wr_aux) begin
      aux_input_result <= REG_WDATA;
    end
  end
endmodule // flrb_bank

// File: tb/flrb_bank_chk.sv
`timescale 1ns/1ps
// Port watcher for fault log, read port and alert
module flrb_bank_chk (
  input wire CORE_CLK,
  input wire RST_N,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  input wire [5:0] ALERT_EN,
  input wire SWITCH_ON_CMD,
  input wire OC_FAULT,
  input wire HIGH_SUPPLY_TRIP_INPUT,
  input wire OUTPUT_LEVEL_MONITOR,
  input wire LOW_SUPPLY_TRIP_INPUT,
  input wire CONV_VALID,
  input wire [1:0] CONV_CHAN,
  input wire [7:0] CONV_CODE,
  input wire ALERT_N,
  input wire [7:0] FAULT_LOG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Host write to the fault log
  wire clr = REG_WR && REG_ADDR == 8'h03;
  a_rvalid_after_read: assert property (REG_RD |=> REG_RVALID)
    else $error("no rvalid");
  a_top_bits_zero: assert property (FAULT_LOG[7:6] == 2'h0)
    else $error("top bits");
  a_flags_stay_set: assert property (!clr |=> (FAULT_LOG | $past(FAULT_LOG)) == FAULT_LOG)
    else $error("flag lost");
  a_read_log_value: assert property (REG_RD && !clr && REG_ADDR == 8'h03 |=> REG_RDATA == $past(FAULT_LOG))
    else $error("log read");
  a_oc_sets_flag: assert property (OC_FAULT |=> FAULT_LOG[2])
    else $error("oc flag");
  a_ov_sets_flag: assert property ($rose(HIGH_SUPPLY_TRIP_INPUT) |-> ##[1:3] FAULT_LOG[0])
    else $error("ov flag");
  a_pbad_sets_flag: assert property ((!OUTPUT_LEVEL_MONITOR) [*3] |=> FAULT_LOG[3])
    else $error("power bad flag");
  a_uv_sets_flag: assert property ((!LOW_SUPPLY_TRIP_INPUT) [*3] |=> FAULT_LOG[1])
    else $error("uv flag");
  a_short_sets_flag: assert property (CONV_VALID && CONV_CHAN == 2'h0 && CONV_CODE > 8'h06
    && !SWITCH_ON_CMD ##1 !SWITCH_ON_CMD |-> ##[0:1] FAULT_LOG[5]) else $error("short flag");
  a_alert_masked: assert property ($stable(ALERT_EN) |-> ALERT_N == !(|(FAULT_LOG[5:0] & ALERT_EN)))
    else $error("alert");
  c_alert: cover property (!ALERT_N);
  c_short: cover property (FAULT_LOG[5]);
  c_clear: cover property (clr ##1 FAULT_LOG == 8'h00);
endmodule // flrb_bank_chk

bind flrb_bank flrb_bank_chk flrb_bank_chk_inst (
  .CORE_CLK(CORE_CLK),
  .RST_N(RST_N),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID),
  .ALERT_EN(ALERT_EN),
  .SWITCH_ON_CMD(SWITCH_ON_CMD),
  .OC_FAULT(OC_FAULT),
  .HIGH_SUPPLY_TRIP_INPUT(HIGH_SUPPLY_TRIP_INPUT),
  .OUTPUT_LEVEL_MONITOR(OUTPUT_LEVEL_MONITOR),
  .LOW_SUPPLY_TRIP_INPUT(LOW_SUPPLY_TRIP_INPUT),
  .CONV_VALID(CONV_VALID),
  .CONV_CHAN(CONV_CHAN),
  .CONV_CODE(CONV_CODE),
  .ALERT_N(ALERT_N),
  .FAULT_LOG(FAULT_LOG)
);

// File: tb/flrb_host.sv
`timescale 1ns/1ps
// Host end of the register link: byte writes and reads
module flrb_host (
  input wire clk,
  input wire [7:0] rdata,
  input wire rvalid,
  output reg wr,
  output reg rd,
  output reg [7:0] addr,
  output reg [7:0] wdata
);
  initial {wr, rd, addr, wdata} = 18'h0;
  // One byte write; zeros clear fault flags
  task wb(input [7:0] a, input [7:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  // One byte read, taken at the rising edge that sees the answer valid
  task rb(input [7:0] a, output [7:0] d);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) d = rvalid ? rdata : 8'hXX;
  endtask
endmodule // flrb_host

// File: tb/flrb_bank_test.sv
`timescale 1ns/1ps
// Self-checking bench for the fault log and result bank
module flrb_bank_test;
  reg clk = 1'b0, rst_n = 1'b0, sw = 1'b0, oc = 1'b0, act = 1'b0, mon = 1'b1, hi = 1'b0;
  reg lo = 1'b1, cv = 1'b0;
  reg [1:0] cch = 2'h0;
  reg [7:0] ccode = 8'h00, d;
  reg [5:0] aen = 6'h00;
  wire wr, rd, rv, al_n;
  wire [7:0] addr, wdata, rdata, flog;
  integer mismatches = 0, checks = 0;
  flrb_host flrb_host_inst (.clk(clk), .rdata(rdata), .rvalid(rv), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata));
  flrb_bank flrb_bank_inst (.CORE_CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rv), .ALERT_EN(aen),
    .SWITCH_ON_CMD(sw), .OC_FAULT(oc), .BOARD_ACTIVATE(act), .OUTPUT_LEVEL_MONITOR(mon),
    .HIGH_SUPPLY_TRIP_INPUT(hi), .LOW_SUPPLY_TRIP_INPUT(lo), .CONV_VALID(cv),
    .CONV_CHAN(cch), .CONV_CODE(ccode), .ALERT_N(al_n), .FAULT_LOG(flog));
  initial forever #12.5 clk = ~clk;
  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    checks = checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    flrb_host_inst.rb(a, d);
    chk(d, e);
  endtask
  task conv(input [1:0] c, input [7:0] v);
    @(posedge clk) {cv, cch, ccode} <= {1'b1, c, v};
    @(posedge clk) cv <= 1'b0;
  endtask
  // Results per channel; sense code 6 with switch off is no short
  task t_results;
    conv(2'h0, 8'h06);
    conv(2'h1, 8'hFF);
    conv(2'h2, 8'hA5);
    conv(2'h3, 8'h3C);
    rdchk(8'h04, 8'h06);
    rdchk(8'h05, 8'hFF);
    rdchk(8'h06, 8'hA5);
    rdchk(8'h07, 8'h00);
    rdchk(8'h03, 8'h00);
  endtask
  // Raise or drop one fault cause
  task ev(input integer i, input v);
    @(posedge clk) case (i)
      0: hi <= v;
      1: lo <= !v;
      2: oc <= v;
      3: mon <= !v;
      4: act <= v;
      default: if (v) conv(2'h0, 8'h07); else sw <= 1'b1;
    endcase
  endtask
  // Each cause sets its own flag, alerts when enabled, clears by zero write
  task t_faults;
    integer i;
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk) aen <= i[0] ? 6'h00 : 6'h3F;
      ev(i, 1'b1);
      repeat (5) @(posedge clk);
      ev(i, 1'b0);
      repeat (5) @(posedge clk);
      chk({7'h00, al_n}, {7'h00, i[0]});
      chk(flog, 8'h01 << i);
      rdchk(8'h03, 8'h01 << i);
      flrb_host_inst.wb(8'h03, 8'h00);
      rdchk(8'h03, 8'h00);
    end
  endtask
  // Mid-run reset with idle pins and the enable pin high: no false flags
  task t_reset;
    @(posedge clk) {act, rst_n} <= 2'b10;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(flog, 8'h00);
    repeat (4) @(posedge clk);
    rdchk(8'h03, 8'h00);
    chk({7'h00, al_n}, 8'h01);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(8'h03, 8'h00);
    flrb_host_inst.wb(8'h03, 8'h00);
    rdchk(8'h03, 8'h00);
    t_results;
    t_faults;
    t_reset;
    test_done;
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // flrb_bank_test
